/* rpch_consts.svh */
// rpch_consts.svh: offsets, defaults and timing of the rectifier command handler
`ifndef RPCH_CONSTS_SVH
`define RPCH_CONSTS_SVH
// command codes
`define RPCH_C_OPER 8'h01
`define RPCH_C_CLRF 8'h03
`define RPCH_C_WPROT 8'h10
`define RPCH_C_RSTF 8'h12
`define RPCH_C_RSTU 8'h16
`define RPCH_C_STOU 8'h17
`define RPCH_C_RSTS 8'h18
`define RPCH_C_VMODE 8'h20
`define RPCH_C_VCMD 8'h21
`define RPCH_C_VINON 8'h35
`define RPCH_C_VINOFF 8'h36
`define RPCH_C_FCFG 8'h3A
`define RPCH_C_FAN1 8'h3B
`define RPCH_C_FAN2 8'h3C
`define RPCH_C_OVTRIP 8'h40
`define RPCH_C_OVACT 8'h41
`define RPCH_C_OVWARN 8'h42
`define RPCH_C_UVWARN 8'h43
`define RPCH_C_UVTRIP 8'h44
`define RPCH_C_UVACT 8'h45
`define RPCH_C_OCTRIP 8'h46
`define RPCH_C_OCACT 8'h47
`define RPCH_C_OCWARN 8'h4A
`define RPCH_C_OTTRIP 8'h4F
`define RPCH_C_STVOUT 8'h7A
`define RPCH_C_STCML 8'h7E
// data codes
`define RPCH_ON 8'h80
`define RPCH_OFF 8'h00
`define RPCH_WP_ALL 8'h00
`define RPCH_WP_NONE 8'h80
`define RPCH_WP_OPER 8'h40
`define RPCH_FAN_MAX 8'h64
`define RPCH_ACT_LATCH 8'h80
`define RPCH_ACT_RESTART 8'hC0
`define RPCH_OC_LATCH 8'hC0
`define RPCH_OC_HICCUP 8'hF8
// setpoint scale 400 per volt: 48 V and 56 V
`define RPCH_VSET_MIN 16'h4B00
`define RPCH_VSET_MAX 16'h5780
// factory defaults (54 V, 59 V, 56 V, 45 V, 44 V at 400 per volt)
`define RPCH_D_VCMD 16'h5460
`define RPCH_D_OVTRIP 16'h5C30
`define RPCH_D_OVWARN 16'h5780
`define RPCH_D_UVWARN 16'h4650
`define RPCH_D_UVTRIP 16'h44C0
`define RPCH_D_OCTRIP 16'h0250
`define RPCH_D_OCWARN 16'h0241
`define RPCH_D_OTTRIP 16'h0078
`define RPCH_D_OVACT 8'h80
`define RPCH_VMODE 8'h17
`define RPCH_VIN_LL_ON 16'h005A
`define RPCH_VIN_LL_OFF 16'h0055
`define RPCH_VIN_HL_ON 16'h00B4
`define RPCH_VIN_HL_OFF 16'h00AF
// status bit positions
`define RPCH_CML_CMD 7
`define RPCH_CML_DATA 6
`define RPCH_CML_PEC 5
`define RPCH_SV_OVF 7
`define RPCH_SV_OVW 6
`define RPCH_SV_UVW 5
`define RPCH_SV_UVF 4
// timing
`define RPCH_CLK_KHZ 50000
`define RPCH_RETRY_MS 1000
`define RPCH_WINDOW_MS 60000
`define RPCH_SHUT_LIMIT 2'd3
`endif

/* rpch_pkg.sv */
// rpch_pkg.sv: types of the rectifier command handler
package rpch_pkg;
  typedef logic [7:0] rpch_code_t;
  typedef logic [15:0] rpch_word_t;
  // overvoltage recovery: run, wait before retry, latched off (gray coded)
  typedef enum logic [1:0] {RPCH_OV_RUN = 2'b00, RPCH_OV_WAIT = 2'b01,
    RPCH_OV_LATCH = 2'b11} rpch_ov_e;
endpackage

/* rpch_top.sv */
// rpch_top.sv: command decode, registers and overvoltage recovery of the rectifier
//
// Functional notes
// - on/off takes 0x80 or 0x00; powers up on
// - clear-faults clears status, alert of controlling side
// - clear from non-controlling side changes nothing
// - persisting fault sets status and alert again
// - write lock 00, 80, 40; resets zero
// - reads of supported codes always succeed; lock writes never blocked by the lock
// - lock register never stored as user default
// - restore-factory reloads fixed factory defaults
// - restore-user reloads all user defaults
// - store/restore single register user default
// - format register reads linear, fixed exponent
// - setpoint is volts times 400, 16 bit
// - setpoint accepted only 48 to 56 volts
// - software setpoint overrides pin until reset
// - input thresholds read-only, depend on line mode
// - fan duty percent, zero internal, overrange error
// - second fan code rejected as invalid command
// - overvoltage: retries one second apart, then latch
// - window ends early: count cleared, new window
// - latch cleared by off-on cycle; clears status
// - alert when output above overvoltage warning
// - comm status bits 7 cmd, 6 data, 5 pec
`timescale 1ns/1ps
`include "rpch_consts.svh"
module rpch_top #(
  parameter logic [31:0] RETRY_CYCLES = 32'(`RPCH_RETRY_MS * `RPCH_CLK_KHZ),
  parameter logic [31:0] WINDOW_CYCLES = 32'(64'(`RPCH_WINDOW_MS) * `RPCH_CLK_KHZ)
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cmd_valid, // one-cycle command strobe
  input wire logic cmd_write,
  input wire rpch_pkg::rpch_code_t cmd_code,
  input wire rpch_pkg::rpch_word_t cmd_data,
  input wire logic cmd_side, // bus side of the request, 0 = a, 1 = b
  input wire logic ctrl_side, // bus side currently in control
  input wire logic pec_error, // one-cycle pulse: packet check failed
  input wire logic onoff_pin, // high = output enabled by hardware
  input wire rpch_pkg::rpch_word_t voltage_program_pin,
  input wire logic high_line,
  input wire logic ov_fault_in, // overvoltage detected by power stage
  input wire rpch_pkg::rpch_word_t vout_meas,
  output logic rsp_valid,
  output logic rsp_ok,
  output rpch_pkg::rpch_word_t rsp_data,
  output logic out_enable,
  output rpch_pkg::rpch_word_t vout_target,
  output logic [7:0] fan_duty, // 0 = internal control
  output logic alert_a_n,
  output logic alert_b_n
);
  import rpch_pkg::*;
  localparam int NREG = 13;

  ////////////////////////////////////////////////////////////////////////////
  // register index map shared by access, store and restore
  function automatic logic [4:0] reg_idx(input rpch_code_t c);
    case (c)
      `RPCH_C_OPER: reg_idx = 5'h00;
      `RPCH_C_VCMD: reg_idx = 5'h01;
      `RPCH_C_FCFG: reg_idx = 5'h02;
      `RPCH_C_FAN1: reg_idx = 5'h03;
      `RPCH_C_OVTRIP: reg_idx = 5'h04;
      `RPCH_C_OVWARN: reg_idx = 5'h05;
      `RPCH_C_UVWARN: reg_idx = 5'h06;
      `RPCH_C_UVTRIP: reg_idx = 5'h07;
      `RPCH_C_UVACT: reg_idx = 5'h08;
      `RPCH_C_OCTRIP: reg_idx = 5'h09;
      `RPCH_C_OCACT: reg_idx = 5'h0A;
      `RPCH_C_OCWARN: reg_idx = 5'h0B;
      `RPCH_C_OTTRIP: reg_idx = 5'h0C;
      default: reg_idx = 5'h1F; // not a stored register
    endcase
  endfunction

  // factory defaults, fixed in logic so they cannot be altered
  function automatic rpch_word_t fdef(input int i);
    case (i)
      0: fdef = {8'h00, `RPCH_ON};
      1: fdef = `RPCH_D_VCMD;
      4: fdef = `RPCH_D_OVTRIP;
      5: fdef = `RPCH_D_OVWARN;
      6: fdef = `RPCH_D_UVWARN;
      7: fdef = `RPCH_D_UVTRIP;
      8: fdef = {8'h00, `RPCH_ACT_RESTART};
      9: fdef = `RPCH_D_OCTRIP;
      10: fdef = {8'h00, `RPCH_OC_HICCUP};
      11: fdef = `RPCH_D_OCWARN;
      12: fdef = `RPCH_D_OTTRIP;
      default: fdef = 16'h0000; // duty control, fans internal
    endcase
  endfunction

  // data legality per register
  function automatic logic data_ok(input logic [4:0] i, input rpch_word_t d);
    case (i)
      5'h00: data_ok = d[7:0] == `RPCH_ON || d[7:0] == `RPCH_OFF;
      5'h01: data_ok = d >= `RPCH_VSET_MIN && d <= `RPCH_VSET_MAX;
      5'h03: data_ok = d[7:0] <= `RPCH_FAN_MAX;
      5'h08: data_ok = d[7:0] == `RPCH_ACT_LATCH || d[7:0] == `RPCH_ACT_RESTART;
      5'h0A: data_ok = d[7:0] == `RPCH_OC_LATCH || d[7:0] == `RPCH_OC_HICCUP;
      default: data_ok = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  rpch_word_t regs_r [NREG]; // operating registers
  rpch_word_t udef_r [NREG]; // user default set
  logic [7:0] wp_r; // write lock
  logic sw_set_r; // software owns the setpoint
  logic [7:0] cml_r; // communication status
  logic [7:0] vstat_r; // output voltage status
  rpch_ov_e ov_st_r;
  logic [1:0] shut_cnt_r; // shutdowns in current window
  logic [31:0] retry_cnt_r;
  logic [31:0] win_cnt_r;
  logic win_act_r;
  logic op_on_d_r; // previous on/off command state
  logic pin_d_r; // previous hardware pin

  // decode of the present command
  logic [4:0] idx;
  logic [4:0] tidx; // target of store/restore single
  logic is_clr_ctrl;
  logic wr_allowed;
  logic restart;
  logic ov_trip;
  logic win_end;
  assign idx = reg_idx(cmd_code);
  assign tidx = reg_idx(cmd_data[7:0]);
  // clear is a send-only command; a read of its code is an unsupported access
  assign is_clr_ctrl = cmd_valid && cmd_write && cmd_code == `RPCH_C_CLRF &&
    cmd_side == ctrl_side;
  // lock gating; the lock register itself is always writable
  assign wr_allowed = cmd_code == `RPCH_C_WPROT || wp_r == `RPCH_WP_ALL ||
    (wp_r == `RPCH_WP_OPER && cmd_code == `RPCH_C_OPER);
  // off then on, by command or by pin
  assign restart = (regs_r[0][7] && !op_on_d_r) || (onoff_pin && !pin_d_r);
  assign ov_trip = ov_st_r == RPCH_OV_RUN && out_enable && ov_fault_in;
  assign win_end = win_act_r && win_cnt_r >= WINDOW_CYCLES - 32'd1;

  ////////////////////////////////////////////////////////////////////////////
  // command execution and response; rejected writes change no register, only the comm status
  logic rej_cmd; // unsupported or read-only or locked
  logic rej_data;
  logic do_wr;
  always_comb
  begin
    rej_cmd = 1'b0;
    rej_data = 1'b0;
    do_wr = 1'b0;
    if (cmd_valid && cmd_write)
    begin
      case (cmd_code)
        `RPCH_C_CLRF, `RPCH_C_WPROT, `RPCH_C_RSTF, `RPCH_C_RSTU: ;
        `RPCH_C_STOU, `RPCH_C_RSTS: rej_data = tidx == 5'h1F; // lock has no slot
        default:
        begin
          if (idx == 5'h1F)
            rej_cmd = 1'b1; // read-only or unknown code
          else
            rej_data = !data_ok(idx, cmd_data);
        end
      endcase
      if (cmd_code == `RPCH_C_WPROT)
        rej_data = cmd_data[7:0] != `RPCH_WP_ALL && cmd_data[7:0] != `RPCH_WP_NONE &&
          cmd_data[7:0] != `RPCH_WP_OPER;
      if (!wr_allowed && cmd_code != `RPCH_C_CLRF)
        rej_cmd = 1'b1;
      do_wr = !rej_cmd && !rej_data;
    end
  end

  // operating registers and user defaults
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        regs_r[i] <= fdef(i);
        udef_r[i] <= fdef(i);
      end
    end
    else if (do_wr)
    begin
      case (cmd_code)
        `RPCH_C_RSTF:
          for (int i = 0; i < NREG; i++)
            regs_r[i] <= fdef(i);
        `RPCH_C_RSTU:
          for (int i = 0; i < NREG; i++)
            regs_r[i] <= udef_r[i];
        `RPCH_C_STOU: udef_r[tidx[3:0]] <= regs_r[tidx[3:0]];
        `RPCH_C_RSTS: regs_r[tidx[3:0]] <= udef_r[tidx[3:0]];
        `RPCH_C_CLRF, `RPCH_C_WPROT: ;
        // only the low byte is checked, so the upper byte must not be kept
        `RPCH_C_OPER: regs_r[0] <= {8'h00, cmd_data[7:0]};
        default: regs_r[idx[3:0]] <= cmd_data;
      endcase
    end
  end

  // write lock, reset to all writes enabled
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wp_r <= `RPCH_WP_ALL;
    else if (do_wr && cmd_code == `RPCH_C_WPROT)
      wp_r <= cmd_data[7:0];
  end

  // once software writes the setpoint the pin is ignored until power loss
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sw_set_r <= 1'b0;
    else if (do_wr && cmd_code == `RPCH_C_VCMD)
      sw_set_r <= 1'b1;
  end

  // read mux and response strobe; reads never depend on the lock
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      rsp_valid <= cmd_valid;
      rsp_ok <= cmd_write ? do_wr : 1'b1;
      rsp_data <= 16'h0000;
      if (cmd_valid && !cmd_write)
      begin
        case (cmd_code)
          `RPCH_C_WPROT: rsp_data <= {8'h00, wp_r};
          `RPCH_C_VMODE: rsp_data <= {8'h00, `RPCH_VMODE};
          `RPCH_C_VINON: rsp_data <= high_line ? `RPCH_VIN_HL_ON : `RPCH_VIN_LL_ON;
          `RPCH_C_VINOFF: rsp_data <= high_line ? `RPCH_VIN_HL_OFF : `RPCH_VIN_LL_OFF;
          `RPCH_C_OVACT: rsp_data <= {8'h00, `RPCH_D_OVACT};
          `RPCH_C_STVOUT: rsp_data <= {8'h00, vstat_r};
          `RPCH_C_STCML: rsp_data <= {8'h00, cml_r};
          default:
          begin
            if (idx != 5'h1F)
              rsp_data <= regs_r[idx[3:0]];
            else
              rsp_ok <= 1'b0; // unsupported code, incl. second fan
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: events set, controlling-side clear or restart clears; set wins
  logic bad_read;
  assign bad_read = cmd_valid && !cmd_write && idx == 5'h1F && !(cmd_code inside
    {`RPCH_C_WPROT, `RPCH_C_VMODE, `RPCH_C_VINON, `RPCH_C_VINOFF, `RPCH_C_OVACT,
     `RPCH_C_STVOUT, `RPCH_C_STCML});
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cml_r <= 8'h00;
    else
    begin
      if (is_clr_ctrl || restart)
        cml_r <= 8'h00;
      if (rej_cmd || bad_read)
        cml_r[`RPCH_CML_CMD] <= 1'b1;
      if (rej_data)
        cml_r[`RPCH_CML_DATA] <= 1'b1;
      if (pec_error)
        cml_r[`RPCH_CML_PEC] <= 1'b1;
    end
  end

  // live conditions re-set their bits in the same cycle as a clear
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      vstat_r <= 8'h00;
    else
    begin
      if (is_clr_ctrl || restart)
        vstat_r <= 8'h00;
      if (ov_trip)
        vstat_r[`RPCH_SV_OVF] <= 1'b1;
      if (vout_meas > regs_r[5])
        vstat_r[`RPCH_SV_OVW] <= 1'b1;
      if (vout_meas < regs_r[6])
        vstat_r[`RPCH_SV_UVW] <= 1'b1;
      if (out_enable && vout_meas < regs_r[7])
        vstat_r[`RPCH_SV_UVF] <= 1'b1;
    end
  end

  // alert only on the side in control, from the sticky status
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alert_a_n <= 1'b1;
      alert_b_n <= 1'b1;
    end
    else
    begin
      alert_a_n <= !((|vstat_r || |cml_r) && !ctrl_side);
      alert_b_n <= !((|vstat_r || |cml_r) && ctrl_side);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overvoltage recovery: retry each second, latch on the third trip in a window
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ov_st_r <= RPCH_OV_RUN;
      shut_cnt_r <= 2'd0;
      retry_cnt_r <= 32'd0;
    end
    else if (restart)
    begin
      ov_st_r <= RPCH_OV_RUN;
      shut_cnt_r <= 2'd0;
    end
    else
    begin
      if (win_end && ov_st_r != RPCH_OV_LATCH)
        shut_cnt_r <= 2'd0;
      case (ov_st_r)
        RPCH_OV_RUN:
        begin
          if (ov_trip)
          begin
            shut_cnt_r <= win_end ? 2'd1 : shut_cnt_r + 2'd1;
            retry_cnt_r <= 32'd0;
            if (!win_end && shut_cnt_r + 2'd1 >= `RPCH_SHUT_LIMIT)
              ov_st_r <= RPCH_OV_LATCH;
            else
              ov_st_r <= RPCH_OV_WAIT;
          end
        end
        RPCH_OV_WAIT:
        begin
          retry_cnt_r <= retry_cnt_r + 32'd1;
          if (retry_cnt_r >= RETRY_CYCLES - 32'd1)
            ov_st_r <= RPCH_OV_RUN;
        end
        RPCH_OV_LATCH: ; // held until off-on cycle
        default: ov_st_r <= RPCH_OV_RUN;
      endcase
    end
  end

  // one-minute window opened by the first trip
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      win_act_r <= 1'b0;
      win_cnt_r <= 32'd0;
    end
    else if (restart || win_end)
    begin
      win_act_r <= ov_trip && !restart; // a trip at expiry starts the next window
      win_cnt_r <= 32'd0;
    end
    else if (ov_trip && !win_act_r)
      win_act_r <= 1'b1;
    else if (win_act_r)
      win_cnt_r <= win_cnt_r + 32'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the power stage and fans
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_on_d_r <= 1'b1;
      pin_d_r <= 1'b1;
      out_enable <= 1'b0;
      vout_target <= `RPCH_D_VCMD;
      fan_duty <= 8'h00;
    end
    else
    begin
      op_on_d_r <= regs_r[0][7];
      pin_d_r <= onoff_pin;
      out_enable <= regs_r[0][7] && onoff_pin && ov_st_r == RPCH_OV_RUN && !ov_trip;
      vout_target <= sw_set_r ? regs_r[1] : voltage_program_pin;
      fan_duty <= regs_r[3][7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_oper_vals;
    @(posedge mclk) disable iff (!reset_n) regs_r[0] == 16'h0080 || regs_r[0] == 16'h0000;
  endproperty
  a_oper_vals: assert property (p_oper_vals) else $error("bad on/off value");
  property p_clr_ctrl;
    @(posedge mclk) disable iff (!reset_n) is_clr_ctrl && !pec_error |=> cml_r == 8'h00;
  endproperty
  a_clr_ctrl: assert property (p_clr_ctrl) else $error("clear did not clear");
  property p_clr_other;
    @(posedge mclk) disable iff (!reset_n)
      cmd_valid && cmd_write && cmd_code == `RPCH_C_CLRF && cmd_side != ctrl_side &&
      !pec_error && !restart
      |=> $stable(cml_r);
  endproperty
  a_clr_other: assert property (p_clr_other) else $error("foreign clear acted");
  property p_wp_vals;
    @(posedge mclk) disable iff (!reset_n) wp_r inside {8'h00, 8'h40, 8'h80};
  endproperty
  a_wp_vals: assert property (p_wp_vals) else $error("bad lock value");
  property p_store_wp;
    @(posedge mclk) disable iff (!reset_n) cmd_valid && cmd_write &&
      cmd_code == `RPCH_C_STOU && cmd_data[7:0] == `RPCH_C_WPROT && wr_allowed
      |=> cml_r[`RPCH_CML_DATA] && !rsp_ok;
  endproperty
  a_store_wp: assert property (p_store_wp) else $error("lock stored");
  property p_vset_range;
    @(posedge mclk) disable iff (!reset_n) regs_r[1] >= `RPCH_VSET_MIN && regs_r[1] <= `RPCH_VSET_MAX;
  endproperty
  a_vset_range: assert property (p_vset_range) else $error("setpoint out of range");
  property p_fan_cmd2;
    @(posedge mclk) disable iff (!reset_n)
      cmd_valid && cmd_code == `RPCH_C_FAN2 |=> cml_r[`RPCH_CML_CMD] && !rsp_ok && rsp_valid;
  endproperty
  a_fan_cmd2: assert property (p_fan_cmd2) else $error("second fan code accepted");
  property p_latch_off;
    @(posedge mclk) disable iff (!reset_n) ov_st_r == RPCH_OV_LATCH ##1 ov_st_r == RPCH_OV_LATCH
      |-> !out_enable;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("output on while latched");
  property p_ov_warn;
    @(posedge mclk) disable iff (!reset_n)
      vout_meas > regs_r[5] |=> vstat_r[`RPCH_SV_OVW] ##1 (ctrl_side ? !alert_b_n : !alert_a_n);
  endproperty
  a_ov_warn: assert property (p_ov_warn) else $error("no alert above warning");
  c_latch: cover property (@(posedge mclk) disable iff (!reset_n) ov_st_r == RPCH_OV_LATCH);
  c_retry: cover property (@(posedge mclk) disable iff (!reset_n)
    ov_st_r == RPCH_OV_WAIT ##1 ov_st_r == RPCH_OV_RUN);
  c_sw_set: cover property (@(posedge mclk) disable iff (!reset_n) $rose(sw_set_r));
endmodule

/* rpch_host.sv */
// rpch_host.sv: host controller model that issues commands to the handler
`timescale 1ns/1ps
module rpch_host (
  input wire logic mclk,
  output logic cmd_valid,
  output logic cmd_write,
  output rpch_pkg::rpch_code_t cmd_code,
  output rpch_pkg::rpch_word_t cmd_data,
  output logic cmd_side,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire rpch_pkg::rpch_word_t rsp_data
);
  import rpch_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 16'h0000;
    cmd_side = 1'b0;
  end
  // one request: strobe for one edge, answer sampled after the next edge
  task automatic xfer(input logic w, input rpch_code_t c, input rpch_word_t d,
    input logic s, output logic ok, output rpch_word_t rd);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_data <= d; // whole word, byte order is the bus engine's
    cmd_side <= s;
    @(posedge mclk);
    // released lines carry the inverse so a stale value never passes
    cmd_valid <= 1'b0;
    cmd_write <= ~w;
    cmd_code <= ~c;
    cmd_data <= ~d;
    cmd_side <= ~s;
    #1;
    ok = (rsp_valid === 1'b1) ? rsp_ok : 1'bx;
    rd = rsp_data;
  endtask
  // bus reset of the unit: off, hold off for a scaled gap, on again
  task automatic restart(input int gap);
    logic ok;
    rpch_word_t rd;
    xfer(1'b1, 8'h01, 16'h0000, 1'b0, ok, rd);
    repeat (gap) @(posedge mclk);
    xfer(1'b1, 8'h01, 16'h0080, 1'b0, ok, rd);
  endtask
endmodule

/* tb.sv */
// tb.sv: self-checking bench of the rectifier command handler
`timescale 1ns/1ps
`include "rpch_consts.svh"
module tb;
  import rpch_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic mclk, reset_n, ctrl_side, pec_error, onoff_pin, high_line, ov_fault_in;
  logic cmd_valid, cmd_write, cmd_side, rsp_valid, rsp_ok, out_enable;
  logic alert_a_n, alert_b_n, ok;
  rpch_code_t cmd_code;
  rpch_word_t cmd_data, vpin, vout_meas, rsp_data, vout_target, rdat;
  logic [7:0] fan_duty;
  int n_fail, checks_done, cycles;
  // short retry and window counts keep the run brief
  rpch_top #(.RETRY_CYCLES(32'd20), .WINDOW_CYCLES(32'd200)) u_rpch_top (
    .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_side(cmd_side),
    .ctrl_side(ctrl_side), .pec_error(pec_error), .onoff_pin(onoff_pin),
    .voltage_program_pin(vpin), .high_line(high_line), .ov_fault_in(ov_fault_in),
    .vout_meas(vout_meas), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_data(rsp_data), .out_enable(out_enable), .vout_target(vout_target),
    .fan_duty(fan_duty), .alert_a_n(alert_a_n), .alert_b_n(alert_b_n));
  rpch_host u_rpch_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_side(cmd_side),
    .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data));
  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // hang guard: a stuck handshake ends the run as a failure
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input rpch_word_t got, input rpch_word_t exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input rpch_code_t c, input rpch_word_t d, input logic e);
    u_rpch_host.xfer(1'b1, c, d, 1'b0, ok, rdat);
    chk(16'(ok), 16'(e));
  endtask
  task automatic rd(input rpch_code_t c, input rpch_word_t e);
    u_rpch_host.xfer(1'b0, c, 16'h0000, 1'b0, ok, rdat);
    chk(16'(ok), 16'h0001);
    chk(rdat, e);
  endtask
  // comm status check, then clear it for the next scenario
  task automatic cml(input rpch_word_t e);
    rd(8'h7E, e);
    wr(8'h03, 16'h0000, 1'b1);
  endtask
  task automatic st;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic vdrv(input rpch_word_t v);
    @(posedge mclk);
    vout_meas <= v;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // single overvoltage trip that clears itself, then the timed retry
  task automatic trip;
    @(posedge mclk);
    ov_fault_in <= 1'b1;
    @(posedge mclk);
    ov_fault_in <= 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    chk(16'(out_enable), 16'h0000);
    repeat (20) @(posedge mclk);
    #1;
    chk(16'(out_enable), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    st;
    chk(16'(out_enable), 16'h0001);
    chk(vout_target, vpin);
    rd(8'h01, 16'h0080);
    rd(8'h10, 16'h0000);
    rd(8'h20, {8'h00, `RPCH_VMODE});
    $display("t_reset done");
  endtask
  task automatic t_clear;
    vdrv(16'h5781);
    chk(16'(alert_a_n), 16'h0000);
    chk(16'(alert_b_n), 16'h0001);
    vdrv(16'h5460);
    u_rpch_host.xfer(1'b1, 8'h03, 16'h0000, 1'b1, ok, rdat);
    rd(8'h7A, 16'h0040);
    wr(8'h03, 16'h0000, 1'b1);
    rd(8'h7A, 16'h0000);
    chk(16'(alert_a_n), 16'h0001);
    vdrv(16'h5781);
    wr(8'h03, 16'h0000, 1'b1);
    st;
    rd(8'h7A, 16'h0040);
    chk(16'(alert_a_n), 16'h0000);
    vdrv(16'h5460);
    wr(8'h03, 16'h0000, 1'b1);
    // hand control to side b: alert moves there, side a can no longer clear
    @(posedge mclk);
    ctrl_side <= 1'b1;
    vdrv(16'h5781);
    chk(16'(alert_b_n), 16'h0000);
    chk(16'(alert_a_n), 16'h0001);
    vdrv(16'h5460);
    wr(8'h03, 16'h0000, 1'b1);
    rd(8'h7A, 16'h0040);
    u_rpch_host.xfer(1'b1, 8'h03, 16'h0000, 1'b1, ok, rdat);
    st;
    chk(16'(alert_b_n), 16'h0001);
    @(posedge mclk);
    ctrl_side <= 1'b0;
    $display("t_clear done");
  endtask
  task automatic t_onoff;
    wr(8'h01, 16'h0055, 1'b0);
    cml(16'h0040);
    @(posedge mclk);
    pec_error <= 1'b1;
    @(posedge mclk);
    pec_error <= 1'b0;
    cml(16'h0020);
    wr(8'h01, 16'h0000, 1'b1);
    st;
    chk(16'(out_enable), 16'h0000);
    u_rpch_host.restart(50);
    st;
    chk(16'(out_enable), 16'h0001);
    // pin off-on cycle restarts the unit and clears the comm status
    wr(8'h01, 16'h0055, 1'b0);
    @(posedge mclk);
    onoff_pin <= 1'b0;
    st;
    chk(16'(out_enable), 16'h0000);
    @(posedge mclk);
    onoff_pin <= 1'b1;
    st;
    chk(16'(out_enable), 16'h0001);
    rd(8'h7E, 16'h0000);
    $display("t_onoff done");
  endtask
  task automatic t_setpoint;
    wr(8'h21, 16'h4ED4, 1'b1);
    st;
    chk(vout_target, 16'h4ED4);
    @(posedge mclk);
    vpin <= 16'h5200;
    st;
    chk(vout_target, 16'h4ED4);
    wr(8'h21, 16'h4AFF, 1'b0);
    wr(8'h21, 16'h5781, 1'b0);
    cml(16'h0040);
    wr(8'h21, 16'h4B00, 1'b1);
    wr(8'h21, 16'h5780, 1'b1);
    rd(8'h21, 16'h5780);
    $display("t_setpoint done");
  endtask
  task automatic t_lock;
    wr(8'h10, 16'h0080, 1'b1);
    wr(8'h21, 16'h4E20, 1'b0);
    wr(8'h01, 16'h0080, 1'b0);
    cml(16'h0080);
    rd(8'h21, 16'h5780);
    wr(8'h10, 16'h0040, 1'b1);
    wr(8'h01, 16'h0080, 1'b1);
    wr(8'h3B, 16'h0010, 1'b0);
    wr(8'h10, 16'h0020, 1'b0);
    wr(8'h10, 16'h0000, 1'b1);
    rd(8'h10, 16'h0000);
    wr(8'h03, 16'h0000, 1'b1);
    $display("t_lock done");
  endtask
  task automatic t_fan;
    wr(8'h3B, 16'h0064, 1'b1);
    st;
    chk({8'h00, fan_duty}, 16'h0064);
    wr(8'h3B, 16'h0065, 1'b0);
    cml(16'h0040);
    wr(8'h3B, 16'h0000, 1'b1);
    st;
    chk({8'h00, fan_duty}, 16'h0000);
    wr(8'h3C, 16'h0032, 1'b0);
    cml(16'h0080);
    u_rpch_host.xfer(1'b0, 8'h3C, 16'h0000, 1'b0, ok, rdat);
    chk(16'(ok), 16'h0000);
    cml(16'h0080);
    $display("t_fan done");
  endtask
  task automatic t_readonly;
    wr(8'h20, 16'h0000, 1'b0);
    wr(8'h35, 16'h0000, 1'b0);
    wr(8'h41, 16'h0080, 1'b0);
    cml(16'h0080);
    rd(8'h35, `RPCH_VIN_LL_ON);
    @(posedge mclk);
    high_line <= 1'b1;
    rd(8'h36, `RPCH_VIN_HL_OFF);
    $display("t_readonly done");
  endtask
  task automatic t_store;
    wr(8'h21, 16'h4E20, 1'b1);
    wr(8'h17, 16'h0021, 1'b1);
    wr(8'h21, 16'h5000, 1'b1);
    wr(8'h18, 16'h0021, 1'b1);
    rd(8'h21, 16'h4E20);
    wr(8'h17, 16'h0010, 1'b0);
    wr(8'h12, 16'h0000, 1'b1);
    rd(8'h21, `RPCH_D_VCMD);
    rd(8'h42, `RPCH_D_OVWARN);
    wr(8'h16, 16'h0000, 1'b1);
    rd(8'h21, 16'h4E20);
    wr(8'h03, 16'h0000, 1'b1);
    $display("t_store done");
  endtask
  task automatic t_ov;
    trip;
    trip;
    repeat (250) @(posedge mclk);
    trip;
    @(posedge mclk);
    ov_fault_in <= 1'b1;
    st;
    chk(16'(out_enable), 16'h0000);
    repeat (100) @(posedge mclk);
    ov_fault_in <= 1'b0;
    repeat (40) @(posedge mclk);
    #1;
    chk(16'(out_enable), 16'h0000);
    u_rpch_host.restart(50);
    st;
    chk(16'(out_enable), 16'h0001);
    rd(8'h7A, 16'h0000);
    $display("t_ov done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence: reset for eight cycles, then each scenario in turn
  initial
  begin
    reset_n = 1'b0;
    ctrl_side = 1'b0;
    pec_error = 1'b0;
    onoff_pin = 1'b1;
    high_line = 1'b0;
    ov_fault_in = 1'b0;
    vout_meas = 16'h5460;
    vpin = 16'h5000;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_clear;
    t_onoff;
    t_setpoint;
    t_lock;
    t_fan;
    t_readonly;
    t_store;
    t_ov;
    final_report;
  end
endmodule
